// ===== design/pss_sequencer.sv
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Control bit 3 sets low-ripple burst mode
// - Wait bias delay before converter switching starts
// - Soft start ramp, shortened when output precharged
// - Discharge off at reset, per-converter software enable
// - Discharge applies whenever converter disabled, any reason
// - Power-good monitor per rail sets power-bad flags
// - Any enabled rail dropping below threshold raises interrupt
// - Disabled linear regulator: comparator off, flag good
// - Linear regulators on together from shared pin
// - Undervoltage or overtemperature shuts every rail down
// - Undervoltage lockout disables all converters and regulators
// - Default pins pick converter default voltages
// - Warm reset drives reset low, restores core
// - Warm reset input debounced for thirty milliseconds
// - Reset low at power-up and while backup low
// - Reset hold time set by HOLD_CYC parameter, 100 ms by default
// - System reset output is open drain
// - Power-fail and low-battery flags follow comparators
// - Core voltage returns default on four conditions
// - Linear default-select pins latched once at power-up
// - Linear voltages reprogrammable any time after power-up
// - Rail out of regulation pulls interrupt low
// - Reading power-bad flags releases interrupt, flag stays
module pss_sequencer import pss_pkg::*; #(
	parameter int unsigned BIAS_CYC = BIAS_CYCLES,
	parameter int unsigned SOFT_CYC = SOFT_START_CYCLES,
	parameter int unsigned DEBOUNCE_CYC = WARM_DEBOUNCE_CYCLES,
	parameter int unsigned HOLD_CYC = RESET_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Host pins and straps
	input wire logic core_conv_on,
	input wire logic system_conv_on,
	input wire logic memory_conv_on,
	input wire logic linear_regs_enable,
	input wire logic core_default_sel,
	input wire logic system_default_sel,
	input wire logic memory_default_sel,
	input wire logic linear_default_sel1,
	input wire logic linear_default_sel2,
	input wire logic warm_reset_in,
	// Analog comparator results
	input wire logic uvlo_trip,
	input wire logic thermal_shutdown,
	input wire logic backup_rail_low,
	input wire logic [4:0] rail_below,
	input wire logic power_fail_sense_low,
	input wire logic low_battery_sense_low,
	input wire logic [2:0][6:0] precharge_pct,
	// Converter and regulator controls
	output logic [2:0] conv_switch,
	output logic [2:0] conv_ramp,
	output logic [2:0] low_ripple,
	output logic [2:0] discharge_on,
	output logic [1:0] linear_on,
	output logic [4:0] comparator_en,
	output logic [15:0] core_rail_mv,
	output logic [15:0] system_rail_mv,
	output logic [15:0] memory_rail_mv,
	output logic [15:0] linear_reg_one_mv,
	output logic [15:0] linear_reg_two_mv,
	// Open-drain pins and power-bad flags
	output logic system_reset_n_o,
	output logic system_reset_n_oe,
	output logic int_n_o,
	output logic int_n_oe,
	output logic [7:0] power_bad_flags
);
	pss_state_t st, nx;
	pss_pins_t raw;
	logic shut, conv_en, wr_go, flags_read, new_fault;
	logic [4:0] rail_on, rail_bad, rail_old;
	logic [15:0] core_def;
	logic [7:0] wa;

	function automatic logic [31:0] apply_strb(logic [31:0] old, logic [31:0] d, logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction : apply_strb

	function automatic logic [31:0] soft_len(logic [6:0] pct);
		longint unsigned n;
		n = 64'(SOFT_CYC);
		if (pct >= 7'd95) begin
			return 32'd1;
		end else if (pct > 7'd5) begin
			n = (n * (64'd95 - 64'(pct))) / 64'd90;
		end
		return (n == 64'd0) ? 32'd1 : 32'(n);
	endfunction : soft_len

	function automatic logic [31:0] lin_default(logic [1:0] sel);
		case (sel)
			2'b00: return {MV_3300, MV_1300};
			2'b01: return {MV_3300, MV_2800};
			2'b10: return {MV_1800, MV_1300};
			default: return {MV_3300, MV_1800};
		endcase
	endfunction : lin_default

	assign raw = '{conv_on: {memory_conv_on, system_conv_on, core_conv_on},
		linear_en: linear_regs_enable,
		conv_sel: {memory_default_sel, system_default_sel, core_default_sel},
		lin_sel: {linear_default_sel2, linear_default_sel1}, warm: warm_reset_in,
		uvlo: uvlo_trip, thermal: thermal_shutdown, backup_low: backup_rail_low,
		rail_below: rail_below, pf_low: power_fail_sense_low,
		lb_low: low_battery_sense_low, precharge_pct: precharge_pct};

	always_comb begin
		nx = st;
		// Three-stage sync; a bit moves only when stages two and three agree
		nx.s1 = raw;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.pin = pss_pins_t'((st.s3 & ~(st.s2 ^ st.s3)) | (st.pin & (st.s2 ^ st.s3)));
		shut = st.pin.uvlo | st.pin.thermal;
		conv_en = 1'b0;
		// Converter sequencing; the host may enable them in any order
		for (int i = 0; i < 3; i++) begin
			conv_en = st.pin.conv_on[i] & ~shut;
			case (st.cst[i])
				CS_OFF: begin
					nx.cst[i] = CS_BIAS;
					nx.ccnt[i] = 32'd0;
				end
				CS_BIAS: begin
					if (st.ccnt[i] == 32'(BIAS_CYC - 1)) begin
						nx.cst[i] = CS_RAMP;
						nx.ccnt[i] = soft_len(st.pin.precharge_pct[i]);
					end else begin
						nx.ccnt[i] = st.ccnt[i] + 32'd1;
					end
				end
				CS_RAMP: begin
					if (st.ccnt[i] <= 32'd1) begin
						nx.cst[i] = CS_ON;
					end else begin
						nx.ccnt[i] = st.ccnt[i] - 32'd1;
					end
				end
				CS_ON: nx.cst[i] = CS_ON;
				default: nx.cst[i] = CS_OFF;
			endcase
			if (!conv_en) begin
				nx.cst[i] = CS_OFF;
			end
			nx.conv_switch[i] = (nx.cst[i] == CS_RAMP) || (nx.cst[i] == CS_ON);
			nx.conv_ramp[i] = nx.cst[i] == CS_RAMP;
			nx.disch_on[i] = (nx.cst[i] == CS_OFF) && st.disch[i];
		end
		nx.low_ripple = {3{st.conv_ctrl[LOW_RIPPLE_BIT]}};
		// Both linear regulators start together on the pin's rising edge
		nx.lin_en_prev = st.pin.linear_en;
		if (st.pin.linear_en && !st.lin_en_prev) begin
			nx.lin_sw_on = 2'b11;
		end
		// Straps caught from this edge's agreed value; the filtered copy lags a cycle
		if (st.init_cnt != STRAP_WAIT) begin
			nx.init_cnt = st.init_cnt + 2'd1;
		end else if (!st.sel_latched) begin
			nx.sel_latched = 1'b1;
			nx.lin_volt = lin_default(nx.pin.lin_sel);
		end
		// Warm reset debounce: restarts whenever the input goes back
		if (st.pin.warm != st.warm_stable) begin
			if (st.deb_cnt == 32'(DEBOUNCE_CYC - 1)) begin
				nx.warm_stable = st.pin.warm;
				nx.deb_cnt = 32'd0;
			end else begin
				nx.deb_cnt = st.deb_cnt + 32'd1;
			end
		end else begin
			nx.deb_cnt = 32'd0;
		end
		// Reset hold: restart while backup low or warm reset held
		if (st.pin.backup_low || st.warm_stable) begin
			nx.sys_rst_oe = 1'b1;
			nx.hold_cnt = 32'd0;
		end else if (st.sys_rst_oe) begin
			if (st.hold_cnt == 32'(HOLD_CYC - 1)) begin
				nx.sys_rst_oe = 1'b0;
				nx.hold_cnt = 32'd0;
			end else begin
				nx.hold_cnt = st.hold_cnt + 32'd1;
			end
		end
		// AXI4-Lite write: address and data accepted in either order
		if (s_axi_awvalid && st.awready) begin
			nx.aw_got = 1'b1;
			nx.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			nx.w_got = 1'b1;
			nx.wdata = s_axi_wdata;
			nx.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			nx.bvalid = 1'b0;
		end
		wr_go = st.aw_got && st.w_got && !st.bvalid;
		wa = {st.awaddr[7:2], 2'b00};
		if (wr_go) begin
			nx.aw_got = 1'b0;
			nx.w_got = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = RESP_OKAY;
			case (wa)
				ADDR_CONV_CTRL: nx.conv_ctrl = apply_strb(st.conv_ctrl, st.wdata, st.wstrb);
				ADDR_DISCHARGE: nx.disch = apply_strb(st.disch, st.wdata, st.wstrb);
				ADDR_LIN_ONOFF: begin
					if (st.wstrb[0]) begin
						nx.lin_sw_on = st.wdata[1:0];
					end
				end
				ADDR_LIN_VOLT: nx.lin_volt = apply_strb(st.lin_volt, st.wdata, st.wstrb);
				ADDR_CORE_VOLT: begin
					if (st.wstrb[0]) nx.core_mv[7:0] = st.wdata[7:0];
					if (st.wstrb[1]) nx.core_mv[15:8] = st.wdata[15:8];
				end
				ADDR_POWER_BAD, ADDR_STATUS: nx.bresp = RESP_OKAY;
				default: nx.bresp = RESP_SLVERR;
			endcase
		end
		nx.awready = !nx.aw_got && !nx.bvalid;
		nx.wready = !nx.w_got && !nx.bvalid;
		// Core default follows the live pin; forced on any reset-type condition
		core_def = st.pin.conv_sel[0] ? MV_1600 : MV_1200;
		if (st.warm_stable || st.pin.backup_low || st.pin.uvlo || st.sys_rst_oe) begin
			nx.core_mv = core_def;
		end
		nx.sys_mv = st.pin.conv_sel[1] ? MV_3300 : MV_1800;
		nx.mem_mv = st.pin.conv_sel[2] ? MV_3300 : MV_1800;
		// AXI4-Lite read
		flags_read = 1'b0;
		if (s_axi_rvalid && s_axi_rready) begin
			nx.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			nx.rvalid = 1'b1;
			nx.rresp = RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				ADDR_CONV_CTRL: nx.rdata = st.conv_ctrl;
				ADDR_DISCHARGE: nx.rdata = st.disch;
				ADDR_POWER_BAD: begin
					nx.rdata = {24'h00_0000, st.flags};
					flags_read = 1'b1;
				end
				ADDR_LIN_ONOFF: nx.rdata = {30'h0000_0000, st.lin_sw_on};
				ADDR_LIN_VOLT: nx.rdata = st.lin_volt;
				ADDR_CORE_VOLT: nx.rdata = {16'h0000, st.core_mv};
				ADDR_STATUS: nx.rdata = {24'h00_0000, st.sys_rst_oe, st.warm_stable,
					st.int_oe, st.lin_on, st.conv_switch};
				default: begin
					nx.rdata = 32'h0000_0000;
					nx.rresp = RESP_SLVERR;
				end
			endcase
		end
		nx.arready = !nx.rvalid;
		// Rails and power-good monitors
		nx.lin_on = {2{st.pin.linear_en & ~shut}} & st.lin_sw_on;
		rail_on = {nx.lin_on, nx.cst[2] != CS_OFF, nx.cst[1] != CS_OFF, nx.cst[0] != CS_OFF};
		nx.comp_en = rail_on;
		rail_bad = rail_on & st.pin.rail_below;
		nx.flags = {st.pin.pf_low, st.pin.lb_low, rail_bad[0], rail_bad[1], rail_bad[2],
			rail_bad[4], rail_bad[3], 1'b0};
		rail_old = {st.flags[2], st.flags[1], st.flags[3], st.flags[4], st.flags[5]};
		new_fault = |(rail_bad & ~rail_old);
		// A fresh fault wins over a release by read in the same cycle
		if (new_fault) begin
			nx.int_release = 1'b0;
		end else if (flags_read && st.int_oe) begin
			nx.int_release = 1'b1;
		end else if (rail_bad == 5'h00) begin
			nx.int_release = 1'b0;
		end
		nx.int_oe = (|rail_bad) && !nx.int_release;
		nx.pin_low = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.cst <= {3{CS_OFF}};
			st.conv_ctrl <= CONV_CTRL_RST;
			st.disch <= DISCHARGE_RST;
			st.sys_rst_oe <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign conv_switch = st.conv_switch;
	assign conv_ramp = st.conv_ramp;
	assign low_ripple = st.low_ripple;
	assign discharge_on = st.disch_on;
	assign linear_on = st.lin_on;
	assign comparator_en = st.comp_en;
	assign core_rail_mv = st.core_mv;
	assign system_rail_mv = st.sys_mv;
	assign memory_rail_mv = st.mem_mv;
	assign linear_reg_one_mv = st.lin_volt[15:0];
	assign linear_reg_two_mv = st.lin_volt[31:16];
	assign system_reset_n_o = st.pin_low;
	assign system_reset_n_oe = st.sys_rst_oe;
	assign int_n_o = st.pin_low;
	assign int_n_oe = st.int_oe;
	assign power_bad_flags = st.flags;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence core_bias_done;
		st.cst[0] == CS_BIAS && st.ccnt[0] == 32'(BIAS_CYC - 1) && st.pin.conv_on[0] && !shut;
	endsequence
	sequence warm_taken;
		$rose(st.warm_stable);
	endsequence

	AST_LOW_RIPPLE: assert property ($rose(st.conv_ctrl[LOW_RIPPLE_BIT]) |=> low_ripple == 3'b111)
		else $error("low ripple not applied");
	AST_BIAS_DELAY: assert property (core_bias_done |=> conv_ramp[0] && conv_switch[0])
		else $error("switching did not start after bias delay");
	AST_NO_EARLY_SWITCH: assert property ($rose(st.cst[0] == CS_BIAS) |-> !conv_switch[0] [*4])
		else $error("switching during bias delay");
	AST_DISCHARGE: assert property ($fell(st.pin.conv_on[1]) && st.disch[1] |=> discharge_on[1])
		else $error("discharge missing on disable");
	AST_SHUTDOWN: assert property (st.pin.uvlo |=> conv_switch == 3'b000 && linear_on == 2'b00)
		else $error("rails not shut down on undervoltage");
	AST_LIN_GOOD: assert property (!linear_on[0] |-> !power_bad_flags[1] && !comparator_en[3])
		else $error("disabled linear regulator reports fault");
	AST_INT_RAISE: assert property ($rose(|power_bad_flags[5:1]) |-> int_n_oe)
		else $error("interrupt not raised on rail fault");
	AST_INT_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_POWER_BAD
		&& int_n_oe && !new_fault |=> !int_n_oe)
		else $error("flag read did not release interrupt");
	AST_WARM_RESET: assert property (warm_taken |=> system_reset_n_oe ##1 core_rail_mv == $past(core_def))
		else $error("warm reset did not reset system or core");
	AST_BACKUP_RESET: assert property (st.pin.backup_low |=> system_reset_n_oe && st.hold_cnt == 32'd0)
		else $error("reset not held while backup low");
	AST_HOLD_TIME: assert property ($fell(system_reset_n_oe) |-> $past(st.hold_cnt) == 32'(HOLD_CYC - 1))
		else $error("reset released before hold time");
	AST_OPEN_DRAIN: assert property (system_reset_n_o == 1'b0 && int_n_o == 1'b0)
		else $error("open-drain pin driven high");
endmodule : pss_sequencer

// ===== shared/pss_pkg.sv
package pss_pkg;
	// Clock and timing figures
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam longint unsigned BIAS_DELAY_NS = 170000;
	localparam longint unsigned SOFT_START_NS = 750000;
	localparam longint unsigned WARM_DEBOUNCE_NS = 30000000;
	localparam longint unsigned RESET_HOLD_NS = 100000000;
	localparam int unsigned BIAS_CYCLES =
		32'((BIAS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int unsigned SOFT_START_CYCLES =
		32'((SOFT_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int unsigned WARM_DEBOUNCE_CYCLES =
		32'((WARM_DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int unsigned RESET_HOLD_CYCLES =
		32'((RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	// Register byte offsets
	localparam logic [7:0] ADDR_CONV_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DISCHARGE = 8'h04;
	localparam logic [7:0] ADDR_POWER_BAD = 8'h08;
	localparam logic [7:0] ADDR_LIN_ONOFF = 8'h0C;
	localparam logic [7:0] ADDR_LIN_VOLT = 8'h10;
	localparam logic [7:0] ADDR_CORE_VOLT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// Field positions and reset values
	localparam int unsigned LOW_RIPPLE_BIT = 3;
	localparam logic [31:0] CONV_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DISCHARGE_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Output voltages in millivolts
	localparam logic [15:0] MV_1200 = 16'h04B0;
	localparam logic [15:0] MV_1300 = 16'h0514;
	localparam logic [15:0] MV_1600 = 16'h0640;
	localparam logic [15:0] MV_1800 = 16'h0708;
	localparam logic [15:0] MV_2800 = 16'h0AF0;
	localparam logic [15:0] MV_3300 = 16'h0CE4;

	typedef enum logic [3:0] {
		CS_OFF = 4'b0001,
		CS_BIAS = 4'b0010,
		CS_RAMP = 4'b0100,
		CS_ON = 4'b1000
	} pss_conv_st_t;

	// Rails: [0] core, [1] system, [2] memory, [3] linear one, [4] linear two
	typedef struct packed {
		logic [2:0] conv_on;
		logic linear_en;
		logic [2:0] conv_sel;
		logic [1:0] lin_sel;
		logic warm;
		logic uvlo;
		logic thermal;
		logic backup_low;
		logic [4:0] rail_below;
		logic pf_low;
		logic lb_low;
		logic [2:0][6:0] precharge_pct;
	} pss_pins_t;

	typedef struct packed {
		pss_pins_t s1, s2, s3, pin;
		logic [31:0] conv_ctrl, disch, lin_volt;
		logic [1:0] lin_sw_on;
		logic [15:0] core_mv, sys_mv, mem_mv;
		logic lin_en_prev, sel_latched;
		logic [1:0] init_cnt;
		pss_conv_st_t [2:0] cst;
		logic [2:0][31:0] ccnt;
		logic warm_stable;
		logic [31:0] deb_cnt, hold_cnt;
		logic sys_rst_oe, pin_low;
		logic [7:0] flags;
		logic int_release, int_oe;
		logic [2:0] conv_switch, conv_ramp, low_ripple, disch_on;
		logic [1:0] lin_on;
		logic [4:0] comp_en;
		logic awready, wready, bvalid, arready, rvalid, aw_got, w_got;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata, wdata;
		logic [7:0] awaddr;
		logic [3:0] wstrb;
	} pss_state_t;
endpackage : pss_pkg

// ===== test/pss_host_model.sv
`timescale 1ns/1ps
// Host side of the pins: drives the enables and warm reset
module pss_host_model (
	// Clock
	input wire logic aclk,
	// Reset level seen by the host
	input wire logic system_reset_n,
	// Host pins
	output logic [2:0] conv_on,
	output logic linear_en,
	output logic warm
);
	logic seen_reset;
	initial begin
		conv_on = 3'h0;
		linear_en = 1'b0;
		warm = 1'b0;
	end
	always @(posedge aclk) begin
		seen_reset <= !system_reset_n;
	end
	// Lag lets a scenario play a slow host
	task automatic set_conv(input logic [2:0] v, input int lag);
		repeat (lag + 1) @(posedge aclk);
		conv_on <= v;
	endtask : set_conv
	task automatic set_linear(input logic v);
		@(posedge aclk);
		linear_en <= v;
	endtask : set_linear
	task automatic pulse_warm(input int len);
		@(posedge aclk);
		warm <= 1'b1;
		repeat (len) @(posedge aclk);
		warm <= 1'b0;
	endtask : pulse_warm
endmodule : pss_host_model

// ===== test/pss_sequencer_test.sv
`timescale 1ns/1ps
module pss_sequencer_test import pss_pkg::*;;
	// Short counts keep the run small
	localparam int BIAS = 8;
	localparam int SOFT = 20;
	localparam int DEB = 10;
	localparam int HOLD = 16;
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r, lin_sel, lin_on;
	logic [2:0] conv_on, def_sel, sw, ramp, lowrip, disch;
	logic lin_en, warm, uvlo, therm, bk_low, pf_low, lb_low;
	logic [4:0] below, cmp_en;
	logic [2:0][6:0] pre;
	logic [15:0] core_mv, sys_mv, mem_mv, l1_mv, l2_mv;
	logic rst_o, rst_oe, int_o, int_oe;
	logic [7:0] flags;
	// External pull-up gives the high level
	wire sys_rst_n = rst_oe ? 1'b0 : 1'b1;
	int failures, total_checks;

	pss_sequencer #(.BIAS_CYC(BIAS), .SOFT_CYC(SOFT), .DEBOUNCE_CYC(DEB), .HOLD_CYC(HOLD))
	pss_sequencer_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.core_conv_on(conv_on[0]), .system_conv_on(conv_on[1]),
		.memory_conv_on(conv_on[2]), .linear_regs_enable(lin_en),
		.core_default_sel(def_sel[0]), .system_default_sel(def_sel[1]),
		.memory_default_sel(def_sel[2]), .linear_default_sel1(lin_sel[0]),
		.linear_default_sel2(lin_sel[1]), .warm_reset_in(warm), .uvlo_trip(uvlo),
		.thermal_shutdown(therm), .backup_rail_low(bk_low), .rail_below(below),
		.power_fail_sense_low(pf_low), .low_battery_sense_low(lb_low),
		.precharge_pct(pre), .conv_switch(sw), .conv_ramp(ramp), .low_ripple(lowrip),
		.discharge_on(disch), .linear_on(lin_on), .comparator_en(cmp_en),
		.core_rail_mv(core_mv), .system_rail_mv(sys_mv), .memory_rail_mv(mem_mv),
		.linear_reg_one_mv(l1_mv), .linear_reg_two_mv(l2_mv),
		.system_reset_n_o(rst_o), .system_reset_n_oe(rst_oe), .int_n_o(int_o),
		.int_n_oe(int_oe), .power_bad_flags(flags));

	pss_host_model pss_host_model_inst (.aclk(aclk), .system_reset_n(sys_rst_n),
		.conv_on(conv_on), .linear_en(lin_en), .warm(warm));

	task automatic tally_and_finish;
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic guard(input logic ok);
		if (!ok) begin
			failures++;
			tally_and_finish();
		end
	endtask : guard
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !got; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				got = 1'b1;
				bready <= 1'b0;
			end
		end
		guard(got);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !got; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				got = 1'b1;
				rready <= 1'b0;
			end
		end
		guard(got);
	endtask : axi_rd
	// Extra covers a debounce still running when the count starts
	task automatic hold_check(input int extra);
		int n;
		for (n = 0; n < 60 && rst_oe; n++) @(posedge aclk);
		guard(!rst_oe);
		chk("hold", 1, n >= HOLD - 2 + extra && n <= HOLD + 10 + extra);
	endtask : hold_check

	task automatic sc_startup;
		chk("rst_oe", 1, rst_oe);
		chk("rst_o", 0, rst_o);
		hold_check(0);
		chk("core_mv", MV_1600, core_mv);
		chk("sys_mv", MV_1800, sys_mv);
		chk("mem_mv", MV_3300, mem_mv);
		lin_sel <= 2'b10;
		tick(8);
		chk("l1_mv", MV_2800, l1_mv);
		chk("l2_mv", MV_3300, l2_mv);
		axi_rd(ADDR_DISCHARGE, d, r);
		chk("disch_reg", DISCHARGE_RST, d);
		chk("disch", 0, disch);
		axi_rd(8'hFC, d, r);
		chk("bad_rd", {30'h0, RESP_SLVERR}, {d[29:0], r});
		axi_wr(8'hFC, 32'hFFFF_FFFF, r);
		chk("bad_wr", RESP_SLVERR, r);
	endtask : sc_startup
	task automatic sc_low_ripple;
		axi_wr(ADDR_CONV_CTRL, 32'h0000_0008, r);
		tick(2);
		chk("ripple_on", 3'b111, lowrip);
		axi_wr(ADDR_CONV_CTRL, 32'h0000_0000, r);
		tick(2);
		chk("ripple_off", 0, lowrip);
	endtask : sc_low_ripple
	task automatic sc_start;
		int rs[2];
		int fl[2];
		rs = '{-1, -1};
		fl = '{-1, -1};
		pre[1] <= 7'd50;
		pss_host_model_inst.set_conv(3'b011, 0);
		for (int n = 0; n < 100 && (fl[0] < 0 || fl[1] < 0); n++) begin
			@(posedge aclk);
			for (int i = 0; i < 2; i++) begin
				if (ramp[i] && rs[i] < 0) rs[i] = n;
				if (!ramp[i] && rs[i] >= 0 && fl[i] < 0) fl[i] = n;
			end
		end
		guard(fl[0] >= 0 && fl[1] >= 0);
		chk("bias", 1, rs[0] >= BIAS && rs[0] <= BIAS + 6);
		chk("ramp", 1, fl[0] - rs[0] >= SOFT - 1 && fl[0] - rs[0] <= SOFT + 1);
		chk("ramp_pre", 1, fl[1] - rs[1] >= SOFT / 2 - 1 && fl[1] - rs[1] <= SOFT / 2 + 1);
		chk("switch", 3'b011, sw);
		axi_rd(ADDR_STATUS, d, r);
		chk("status", 32'h0000_0003, d);
	endtask : sc_start
	task automatic sc_power_bad;
		below <= 5'b00010;
		tick(8);
		chk("int_low", 1, int_oe);
		chk("sys_bad", 1, flags[4]);
		axi_rd(ADDR_POWER_BAD, d, r);
		chk("bad_reg", 1, d[4]);
		tick(2);
		chk("int_rel", 0, int_oe);
		chk("bad_kept", 1, flags[4]);
		below <= 5'b00000;
		pf_low <= 1'b1;
		lb_low <= 1'b1;
		tick(8);
		chk("recover", 3'b110, {flags[7:6], flags[4]});
		pf_low <= 1'b0;
		lb_low <= 1'b0;
		tick(8);
		chk("sense_ok", 0, flags[7:6]);
	endtask : sc_power_bad
	task automatic sc_linear;
		pss_host_model_inst.set_linear(1'b1);
		tick(8);
		chk("lin_on", 2'b11, lin_on);
		axi_wr(ADDR_LIN_VOLT, 32'h0708_0514, r);
		tick(2);
		chk("l1_new", MV_1300, l1_mv);
		chk("l2_new", MV_1800, l2_mv);
		axi_wr(ADDR_LIN_ONOFF, 32'h0000_0000, r);
		below <= 5'b01000;
		tick(8);
		chk("lin_off", {2'b00, 2'b00, 2'b00, 1'b0}, {lin_on, cmp_en[4:3], flags[2:1], int_oe});
		below <= 5'b00000;
	endtask : sc_linear
	task automatic sc_shutdown;
		axi_wr(ADDR_DISCHARGE, 32'h0000_0007, r);
		axi_wr(ADDR_CORE_VOLT, 32'h0000_03E8, r);
		tick(2);
		chk("disch_mem", 3'b100, disch);
		chk("core_prog", 16'h03E8, core_mv);
		axi_wr(ADDR_LIN_ONOFF, 32'h0000_0003, r);
		uvlo <= 1'b1;
		pss_host_model_inst.set_conv(3'b111, 2);
		tick(8);
		chk("uvlo", {3'b000, 2'b00, 3'b111}, {sw, lin_on, disch});
		chk("uvlo_core", MV_1600, core_mv);
		uvlo <= 1'b0;
		therm <= 1'b1;
		tick(8);
		chk("therm", {3'b000, 2'b00, 3'b111}, {sw, lin_on, disch});
		therm <= 1'b0;
		tick(40);
	endtask : sc_shutdown
	task automatic sc_warm;
		logic seen;
		seen = 1'b0;
		axi_wr(ADDR_CORE_VOLT, 32'h0000_03E8, r);
		pss_host_model_inst.pulse_warm(DEB - 4);
		repeat (30) begin
			@(posedge aclk);
			seen = seen | rst_oe;
		end
		chk("short_warm", 0, seen);
		chk("core_kept", 16'h03E8, core_mv);
		pss_host_model_inst.pulse_warm(DEB + 10);
		chk("warm_rst", 1, rst_oe);
		chk("warm_core", MV_1600, core_mv);
		chk("host_rst", 1, pss_host_model_inst.seen_reset);
		axi_rd(ADDR_LIN_VOLT, d, r);
		chk("warm_lin", 32'h0708_0514, d);
		hold_check(DEB);
	endtask : sc_warm
	task automatic sc_backup;
		axi_wr(ADDR_CORE_VOLT, 32'h0000_03E8, r);
		bk_low <= 1'b1;
		tick(8);
		chk("bk_rst", 1, rst_oe);
		chk("bk_core", MV_1600, core_mv);
		bk_low <= 1'b0;
		hold_check(0);
	endtask : sc_backup

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		repeat (100000) @(posedge aclk);
		failures++;
		tally_and_finish();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{uvlo, therm, bk_low, pf_low, lb_low, below, pre} = '0;
		def_sel = 3'b101;
		lin_sel = 2'b01;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		tick(2);
		sc_startup();
		sc_low_ripple();
		sc_start();
		sc_power_bad();
		sc_linear();
		sc_shutdown();
		sc_warm();
		sc_backup();
		tally_and_finish();
	end
endmodule : pss_sequencer_test
